// >>> logic/alert_mask_bank.sv
// alert mask bank: per-group masks, host access and the alert output
// assumes link strobes come from a bus engine clocked by LINK_CLK and
// status bytes are latched by converter logic on CORE_CLK
//
// Behaviour
// - mask write: low byte picks the group, high byte is the mask
// - mask read: host sends group code, device answers with that mask byte
// - masks never stop status recording, only its path to the alert
// - mask bit zero lets the condition alert, one blocks it
// - group masks are written by word write to the shared command
// - group masks are read back as one unsigned byte
// - only the all-phases selection is accepted, others are refused
// - masks load from stored values and change while converting
// - output voltage mask: bits 7 to 2 writable, 1:0 read zero
// - current group 7b: bits 7, 5, 4 writable, rest zero
// - input group 7c: bits 7:5 reset zero, bit 3 stored, rest zero
// - temperature group 7d: bits 7 and 6 writable, 5:0 zero
// - comm group 7e: bits 7:3 and 1 writable, 2 and 0 zero
// - each mask is one byte, unsupported bits read-only zero
`default_nettype none

module alert_mask_bank
    import alert_mask_pkg::*;
(
    // core side
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // stored mask values and their load strobe
    input wire logic NVM_LOAD,
    input wire group_bytes_type NVM_MASKS,
    // latched status bytes of the converter
    input wire group_bytes_type STATUS,
    // alert output
    output logic ALERT_N,
    // link side
    input wire logic LINK_CLK,
    input wire logic LINK_WR,
    input wire logic LINK_RD,
    input wire logic [7:0] LINK_CMD,
    input wire logic [7:0] LINK_PHASE,
    input wire logic [7:0] LINK_LOW,
    input wire logic [7:0] LINK_HIGH,
    // link answers
    output logic LINK_BUSY,
    output logic LINK_REFUSE,
    output logic LINK_RD_VALID,
    output logic [7:0] LINK_RD_DATA
);

    // implemented bits
    // keep only the implemented bits of a group
    function automatic logic [7:0] wmask_of(input logic [7:0] sel);
        case (sel)
            VOUT_SEL: wmask_of = VOUT_WMASK;
            IOUT_SEL: wmask_of = IOUT_WMASK;
            INPUT_SEL: wmask_of = INPUT_WMASK;
            TEMP_SEL: wmask_of = TEMP_WMASK;
            CML_SEL: wmask_of = CML_WMASK;
            default: wmask_of = 8'h00;
        endcase
    endfunction : wmask_of

    // loads a whole bank with reserved bits forced low
    function automatic group_bytes_type clean(input group_bytes_type g);
        group_bytes_type r;
        r.vout = g.vout & VOUT_WMASK;
        r.iout = g.iout & IOUT_WMASK;
        // only low-input bit stored
        // bits 7:5 restart at zero on every load, not from storage
        r.input_grp = INPUT_RESET & INPUT_WMASK;
        r.input_grp[LOW_INPUT_POS] = g.input_grp[LOW_INPUT_POS];
        r.temp = g.temp & TEMP_WMASK;
        r.cml = g.cml & CML_WMASK;
        return r;
    endfunction : clean

    // core domain registers
    group_bytes_type mask_q;
    group_bytes_type mask_d;
    logic req_sync1_q;
    logic req_sync2_q;
    logic req_seen_q;
    logic ack_tgl_q;
    logic [7:0] rsp_data_q;
    logic alert_n_q;

    // link domain registers
    logic rst_sync1_q;
    logic link_rst_n_q;
    link_req_type req_q;
    logic req_tgl_q;
    logic pend_q;
    logic ack_sync1_q;
    logic ack_sync2_q;
    logic ack_seen_q;
    logic refuse_q;
    logic rd_valid_q;
    logic [7:0] rd_data_q;

    // core side decode
    wire req_edge = req_sync2_q ^ req_seen_q;
    wire host_write = req_edge && !req_q.rd;
    wire host_read = req_edge && req_q.rd;
    wire [7:0] new_bits = req_q.data & wmask_of(req_q.sel);
    wire group_bytes_type loaded = NVM_LOAD ? clean(NVM_MASKS) : mask_q;

    wire [7:0] read_back =
        (req_q.sel == VOUT_SEL) ? mask_q.vout :
        (req_q.sel == IOUT_SEL) ? mask_q.iout :
        (req_q.sel == INPUT_SEL) ? mask_q.input_grp :
        (req_q.sel == TEMP_SEL) ? mask_q.temp :
        (req_q.sel == CML_SEL) ? mask_q.cml : 8'h00;

    // status read here only; nothing of it is held or cleared
    wire group_bytes_type unmasked = STATUS & ~mask_q;
    wire alert_any = |unmasked;

    // host byte replaces the selected group; load, then host wins
    always_comb begin
        mask_d = loaded;
        if (host_write) begin
            case (req_q.sel)
                VOUT_SEL: mask_d.vout = new_bits;
                IOUT_SEL: mask_d.iout = new_bits;
                INPUT_SEL: mask_d.input_grp = new_bits;
                TEMP_SEL: mask_d.temp = new_bits;
                CML_SEL: mask_d.cml = new_bits;
                default: mask_d = loaded;
            endcase
        end
    end

    // stored values load at any time, conversion never gated
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mask_q <= '{VOUT_RESET, IOUT_RESET, INPUT_RESET, TEMP_RESET, CML_RESET};
        end else begin
            mask_q <= mask_d;
        end
    end

    // request toggle crossing into the core
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            req_sync1_q <= 1'b0;
            req_sync2_q <= 1'b0;
            req_seen_q <= 1'b0;
        end else begin
            req_sync1_q <= req_tgl_q;
            req_sync2_q <= req_sync1_q;
            req_seen_q <= req_sync2_q;
        end
    end

    // one answer byte, held until the next read request
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rsp_data_q <= 8'h00;
            ack_tgl_q <= 1'b0;
        end else if (req_edge) begin
            rsp_data_q <= host_read ? read_back : rsp_data_q;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // alert follows any unmasked status, low active
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            alert_n_q <= 1'b1;
        end else begin
            alert_n_q <= ~alert_any;
        end
    end

    assign ALERT_N = alert_n_q;

    // link side decode
    wire link_strobe = LINK_WR || LINK_RD;
    // wrong command, any phase but all-phases, or busy: refused
    wire link_accept = link_strobe && (LINK_CMD == MASK_CMD) && (LINK_PHASE == ALL_PHASES) && !pend_q;
    wire ack_edge = ack_sync2_q ^ ack_seen_q;

    // core reset carried into the link domain
    always_ff @(posedge LINK_CLK) begin
        rst_sync1_q <= RST_N;
        link_rst_n_q <= rst_sync1_q;
    end

    // request held stable while the toggle crosses
    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n_q) begin
            req_q <= '0;
            req_tgl_q <= 1'b0;
        end else if (link_accept) begin
            req_q <= '{LINK_RD, LINK_LOW, LINK_HIGH};
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // one request in flight; the engine must stretch until done
    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n_q) begin
            pend_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            pend_q <= link_accept || (pend_q && !ack_edge);
            refuse_q <= link_strobe && !link_accept;
        end
    end

    // acknowledge toggle crossing back
    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n_q) begin
            ack_sync1_q <= 1'b0;
            ack_sync2_q <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            ack_sync1_q <= ack_tgl_q;
            ack_sync2_q <= ack_sync1_q;
            ack_seen_q <= ack_sync2_q;
        end
    end

    // answer byte presented once the core has replied
    always_ff @(posedge LINK_CLK) begin
        if (!link_rst_n_q) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            rd_valid_q <= ack_edge && req_q.rd;
            rd_data_q <= (ack_edge && req_q.rd) ? rsp_data_q : rd_data_q;
        end
    end

    assign LINK_BUSY = pend_q;
    assign LINK_REFUSE = refuse_q;
    assign LINK_RD_VALID = rd_valid_q;
    assign LINK_RD_DATA = rd_data_q;

    // checks on the core side
    a_alert_unmasked:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        alert_any |=> !ALERT_N)
        else $error("unmasked status did not raise the alert");

    a_alert_masked:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ((STATUS & mask_q) == STATUS) |=> ALERT_N)
        else $error("fully masked status raised the alert");

    a_vout_reserved:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mask_q.vout & ~VOUT_WMASK) == 8'h00)
        else $error("voltage mask low bits not zero");

    a_iout_reserved:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mask_q.iout & ~IOUT_WMASK) == 8'h00)
        else $error("current mask reserved bits set");

    a_input_reserved:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mask_q.input_grp & ~INPUT_WMASK) == 8'h00)
        else $error("input mask reserved bits set");

    a_temp_reserved:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mask_q.temp & ~TEMP_WMASK) == 8'h00)
        else $error("temperature mask reserved bits set");

    a_cml_reserved:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mask_q.cml & ~CML_WMASK) == 8'h00)
        else $error("comm mask reserved bits set");

    a_write_applies:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (host_write && req_q.sel == IOUT_SEL) |=> mask_q.iout == $past(new_bits))
        else $error("current mask write not applied");

    a_read_byte:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (host_read && req_q.sel == TEMP_SEL) |=> rsp_data_q[5:0] == 6'h00)
        else $error("temperature read shows reserved bits");

    a_write_input:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (host_write && req_q.sel == INPUT_SEL) |=> mask_q.input_grp == ($past(req_q.data) & INPUT_WMASK))
        else $error("input mask write not applied");

    a_write_comm:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (host_write && req_q.sel == CML_SEL) |=> mask_q.cml == ($past(req_q.data) & CML_WMASK))
        else $error("comm mask write not applied");

    // a host write in the same cycle overrides the load, so skip it
    a_load_voltage:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (NVM_LOAD && !host_write) |=> mask_q.vout == ($past(NVM_MASKS.vout) & VOUT_WMASK))
        else $error("stored voltage mask not loaded");

    a_load_input:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (NVM_LOAD && !host_write) |=> ((mask_q.input_grp & ~(8'h01 << LOW_INPUT_POS)) == 8'h00)
            && (mask_q.input_grp[LOW_INPUT_POS] == $past(NVM_MASKS.input_grp[LOW_INPUT_POS])))
        else $error("stored input mask load wrong");

    a_alert_reset:
    assert property (@(posedge CORE_CLK)
        !RST_N |=> ALERT_N)
        else $error("alert active during reset");

    // checks on the link side
    sequence s_read_taken;
        LINK_RD && link_accept;
    endsequence

    sequence s_answer;
        ##[3:20] LINK_RD_VALID;
    endsequence

    a_read_answer:
    assert property (@(posedge LINK_CLK) disable iff (!link_rst_n_q)
        s_read_taken |-> s_answer)
        else $error("read answer missing or late");

    a_phase_refused:
    assert property (@(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (LINK_WR && LINK_PHASE != ALL_PHASES) |=> LINK_REFUSE && $stable(req_tgl_q))
        else $error("other phase value was not refused");

    a_foreign_command:
    assert property (@(posedge LINK_CLK) disable iff (!link_rst_n_q)
        (link_strobe && LINK_CMD != MASK_CMD) |=> LINK_REFUSE && $stable(req_tgl_q))
        else $error("foreign command was not refused");

    a_busy_taken:
    assert property (@(posedge LINK_CLK) disable iff (!link_rst_n_q)
        link_accept |=> LINK_BUSY)
        else $error("accepted request did not raise busy");

endmodule : alert_mask_bank

`default_nettype wire

// >>> logic/alert_mask_pkg.sv
// constants and carrier types for the alert mask bank
// assumes a bus engine outside that decodes link frames into strobes
`default_nettype none

package alert_mask_pkg;

    // command code and phase
    localparam logic [7:0] MASK_CMD = 8'h1b;
    localparam logic [7:0] ALL_PHASES = 8'hff;

    // group selector codes
    localparam logic [7:0] VOUT_SEL = 8'h7a;
    localparam logic [7:0] IOUT_SEL = 8'h7b;
    localparam logic [7:0] INPUT_SEL = 8'h7c;
    localparam logic [7:0] TEMP_SEL = 8'h7d;
    localparam logic [7:0] CML_SEL = 8'h7e;

    // writable bit layouts
    localparam logic [7:0] VOUT_WMASK = 8'hfc;
    localparam logic [7:0] IOUT_WMASK = 8'hb0;
    localparam logic [7:0] INPUT_WMASK = 8'he8;
    localparam logic [7:0] TEMP_WMASK = 8'hc0;
    localparam logic [7:0] CML_WMASK = 8'hfa;

    // field positions used by the converter side
    localparam int OVERCURRENT_FAULT_POS = 7;
    localparam int LOW_INPUT_POS = 3;
    localparam int OTHER_COMM_FAULT_POS = 1;

    // values held until the stored masks are loaded
    localparam logic [7:0] VOUT_RESET = 8'h00;
    localparam logic [7:0] IOUT_RESET = 8'h00;
    localparam logic [7:0] INPUT_RESET = 8'h00;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] CML_RESET = 8'h00;

    // one byte per status group, masks and status alike
    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_grp;
        logic [7:0] temp;
        logic [7:0] cml;
    } group_bytes_type;

    // request handed from the link side to the core side
    typedef struct packed {
        logic rd;
        logic [7:0] sel;
        logic [7:0] data;
    } link_req_type;

endpackage : alert_mask_pkg

`default_nettype wire

// >>> test/link_host.sv
// host model on the link: word writes and process-call reads
// assumes registered busy, refuse and valid answers on link_clk
`default_nettype none

module link_host
    import alert_mask_pkg::*;
(
    // link clock and answers
    input wire logic link_clk,
    input wire logic busy,
    input wire logic refuse,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    // requests
    output var logic wr,
    output var logic rd,
    output var logic [7:0] cmd,
    output var logic [7:0] phase,
    output var logic [7:0] low,
    output var logic [7:0] high
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        wr = 1'b0;
        rd = 1'b0;
        {cmd, phase, low, high} = 32'h0;
    end

    task xfer(input logic rd_i, input logic [7:0] cmd_i, ph_i, sel_i, dat_i,
              output logic ref_o, output logic [7:0] dat_o);
        int n;
        ref_o = 1'b0;
        dat_o = 8'h00;
        @(posedge link_clk);
        wr <= ~rd_i;
        rd <= rd_i;
        {cmd, phase, low, high} <= {cmd_i, ph_i, sel_i, dat_i};
        @(posedge link_clk);
        // released lines show the inverse, not the old value
        wr <= 1'b0;
        rd <= 1'b0;
        {cmd, phase, low, high} <= ~{cmd_i, ph_i, sel_i, dat_i};
        for (n = 0; n < 40; n++) begin
            // answers launched at the last edge, read before they move
            @(posedge link_clk);
            if (refuse === 1'b1) ref_o = 1'b1;
            if (rd_valid === 1'b1) dat_o = rd_data;
            if (n > 0 && busy !== 1'b1) break;
        end
    endtask : xfer
endmodule : link_host

`default_nettype wire

// >>> test/alert_mask_bank_test.sv
// self-checking bench for the alert mask bank
// assumes link_host drives the link side; core inputs driven here
`default_nettype none

module alert_mask_bank_test
    import alert_mask_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic nvm_load = 1'b0;
    group_bytes_type nvm_masks = '0;
    group_bytes_type status = '0;
    logic alert_n, busy, refuse, rd_valid;
    logic [7:0] rd_data;
    logic l_wr, l_rd;
    logic [7:0] l_cmd, l_phase, l_low, l_high;
    int fails = 0;
    int comparisons = 0;
    logic [7:0] sels [5] = '{VOUT_SEL, IOUT_SEL, INPUT_SEL, TEMP_SEL, CML_SEL};
    logic [7:0] wms [5] = '{VOUT_WMASK, IOUT_WMASK, INPUT_WMASK, TEMP_WMASK, CML_WMASK};
    // stored pattern 5a: implemented bits only, input keeps just its low-input bit
    logic [7:0] stored [5] = '{8'h58, 8'h10, 8'h08, 8'h40, 8'h5a};

    alert_mask_bank DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .NVM_LOAD(nvm_load),
        .NVM_MASKS(nvm_masks), .STATUS(status), .ALERT_N(alert_n), .LINK_CLK(link_clk),
        .LINK_WR(l_wr), .LINK_RD(l_rd), .LINK_CMD(l_cmd), .LINK_PHASE(l_phase),
        .LINK_LOW(l_low), .LINK_HIGH(l_high), .LINK_BUSY(busy), .LINK_REFUSE(refuse),
        .LINK_RD_VALID(rd_valid), .LINK_RD_DATA(rd_data));

    link_host host (.link_clk(link_clk), .busy(busy), .refuse(refuse), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr(l_wr), .rd(l_rd), .cmd(l_cmd), .phase(l_phase),
        .low(l_low), .high(l_high));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // odd offset keeps the two clocks out of step
    initial begin
        #17;
        forever #40 link_clk = ~link_clk;
    end

    task conclude;
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task check8(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : check8

    task check1(input logic got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check1

    task access(input logic rd_i, input logic [7:0] cmd_i, ph_i, sel_i, dat_i,
                input logic exp_ref, input logic [7:0] exp_dat);
        logic r;
        logic [7:0] d;
        host.xfer(rd_i, cmd_i, ph_i, sel_i, dat_i, r, d);
        check1(r, exp_ref);
        if (rd_i) check8(d, exp_dat);
    endtask : access

    task core_set(input group_bytes_type s);
        @(posedge core_clk);
        status <= s;
        repeat (5) @(posedge core_clk);
    endtask : core_set

    initial begin
        #500000;
        fails++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge link_clk);
        for (int i = 0; i < 5; i++) access(1, MASK_CMD, ALL_PHASES, sels[i], 8'h00, 0, 8'h00);
        for (int i = 0; i < 5; i++) begin
            access(0, MASK_CMD, ALL_PHASES, sels[i], 8'hff, 0, 8'h00);
            access(1, MASK_CMD, ALL_PHASES, sels[i], 8'h00, 0, wms[i]);
        end
        access(0, MASK_CMD, ALL_PHASES, 8'h7f, 8'hff, 0, 8'h00);
        access(1, MASK_CMD, ALL_PHASES, 8'h7f, 8'h00, 0, 8'h00);
        access(0, MASK_CMD, 8'h00, IOUT_SEL, 8'h00, 1, 8'h00);
        access(0, 8'h1c, ALL_PHASES, IOUT_SEL, 8'h00, 1, 8'h00);
        access(1, MASK_CMD, ALL_PHASES, IOUT_SEL, 8'h00, 0, IOUT_WMASK);
        core_set({VOUT_WMASK, IOUT_WMASK, INPUT_WMASK, TEMP_WMASK, CML_WMASK});
        check1(alert_n, 1'b1);
        // clearing one bit while running must unmask it
        access(0, MASK_CMD, ALL_PHASES, IOUT_SEL, 8'h90, 0, 8'h00);
        repeat (5) @(posedge core_clk);
        check1(alert_n, 1'b0);
        access(0, MASK_CMD, ALL_PHASES, IOUT_SEL, 8'hff, 0, 8'h00);
        repeat (5) @(posedge core_clk);
        check1(alert_n, 1'b1);
        core_set({32'h0, 8'h01});
        check1(alert_n, 1'b0);
        @(posedge core_clk);
        nvm_masks <= {5{8'h5a}};
        nvm_load <= 1'b1;
        @(posedge core_clk);
        nvm_load <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 5; i++) access(1, MASK_CMD, ALL_PHASES, sels[i], 8'h00, 0, stored[i]);
        conclude();
    end
endmodule : alert_mask_bank_test

`default_nettype wire
